// ===== hdl/lsa_pkg.sv
package lsa_pkg;

	// ****************************************************************
	// Clock and sequencer timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam real         VOLT_TIME_MS   = 11.38;
	localparam real         LOCAL_TIME_MS  = 12.0;
	localparam real         REMOTE_TIME_MS = 25.5;
	localparam int unsigned VOLT_CYC   =
		int'(VOLT_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS));
	localparam int unsigned LOCAL_CYC  =
		int'(LOCAL_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS));
	localparam int unsigned REMOTE_CYC =
		int'(REMOTE_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS));
	localparam int unsigned DWELL_W    = 24;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
	localparam logic [7:0] ADDR_CFG_ONE    = 8'h40;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
	localparam logic [7:0] ADDR_LIMIT_BASE = 8'h44;
	localparam logic [7:0] ADDR_TACH_BASE  = 8'h54;
	localparam logic [7:0] ADDR_MASK_ONE   = 8'h74;
	localparam logic [7:0] ADDR_MASK_TWO   = 8'h75;
	localparam logic [7:0] ADDR_CFG_THREE  = 8'h78;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFG1_START_BIT    = 0;
	localparam int CFG3_ALERT_EN_BIT = 0;
	localparam int CFG3_THERMAL_EVENT_PIN_EN_BIT = 1;
	localparam int ST1_SUMMARY_BIT   = 7;
	localparam int ST2_DIODE_TWO     = 7;
	localparam int ST2_DIODE_ONE     = 6;
	localparam int ST2_FAN_FOUR      = 5;
	localparam int ST2_FAN_ONE       = 2;
	localparam int ST2_OVERTEMP      = 1;
	localparam int ST2_TWELVE_VOLT   = 0;

	// ****************************************************************
	// Channels and reset values
	// ****************************************************************
	localparam int NUM_CH       = 8;
	localparam int NUM_VOLT_CH  = 5;
	localparam int LOCAL_CH     = 6;
	localparam int TWELVE_CH    = 4;
	// Nibble per channel: index into {status_two, status_one}
	localparam logic [31:0] CH_STAT_MAP = 32'h6548_3210;
	localparam logic [7:0] VOLT_LO_RST  = 8'h00;
	localparam logic [7:0] VOLT_HI_RST  = 8'hFF;
	localparam logic [7:0] TEMP_LO_RST  = 8'h81;
	localparam logic [7:0] TEMP_HI_RST  = 8'h7F;
	localparam logic [7:0] TACH_LIM_RST = 8'hFF;
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic [63:0] VALUE_RST   = 64'h8080_8000_0000_0000;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b00,
		SEQ_CONV = 2'b01
	} lsa_seq_state_t;

endpackage

// ===== hdl/lsa_value_mem.sv
`timescale 1ns/1ps
module lsa_value_mem
	import lsa_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	input  wire logic       i_we,
	input  wire logic [2:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [2:0] i_raddr,
	output logic      [7:0] o_rdata
);

	logic [7:0] mem_q [NUM_CH];
	logic [7:0] mem_d [NUM_CH];
	logic [7:0] rdata_d;

	// ****************************************************************
	// Storage, one entry per channel
	// ****************************************************************
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_entry
		// Newest result overwrites, so software always sees the latest
		always_comb
		begin
			mem_d[g] = mem_q[g];
			if (i_we && (i_waddr == 3'(g)))
				mem_d[g] = i_wdata;
		end

		always_ff @(posedge i_clk)
		begin
			if (i_rst)
				mem_q[g] <= VALUE_RST[g*8 +: 8];
			else if (i_ce)
				mem_q[g] <= mem_d[g];
		end
	end

	// Registered read port
	always_comb
	begin
		rdata_d = mem_q[i_raddr];
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_rdata <= REG_RST;
		else if (i_ce)
			o_rdata <= rdata_d;
	end

endmodule

// ===== hdl/lsa_sequencer.sv
`timescale 1ns/1ps
module lsa_sequencer
	import lsa_pkg::*;
#(
	parameter int unsigned P_VOLT_CYC   = VOLT_CYC,
	parameter int unsigned P_LOCAL_CYC  = LOCAL_CYC,
	parameter int unsigned P_REMOTE_CYC = REMOTE_CYC
)
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	input  wire logic       i_run,
	output logic            o_start,
	output logic      [2:0] o_channel
);

	lsa_seq_state_t       state_q;
	lsa_seq_state_t       state_d;
	logic [DWELL_W-1:0]   cnt_q;
	logic [DWELL_W-1:0]   cnt_d;
	logic [2:0]           ch_d;
	logic                 start_d;
	logic [DWELL_W-1:0]   dwell;

	// Dwell of the next channel: voltage, local or remote slot
	always_comb
	begin
		if (int'(ch_d) < NUM_VOLT_CH)
			dwell = DWELL_W'(P_VOLT_CYC - 1);
		else if (int'(ch_d) == LOCAL_CH)
			dwell = DWELL_W'(P_LOCAL_CYC - 1);
		else
			dwell = DWELL_W'(P_REMOTE_CYC - 1);
	end

	// ****************************************************************
	// Round-robin slot machine
	// ****************************************************************
	// Dropping run stops at once; a slot in flight is abandoned
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		ch_d    = o_channel;
		start_d = 1'b0;
		case (state_q)
			SEQ_IDLE:
			begin
				ch_d = 3'h0;
				if (i_run)
				begin
					state_d = SEQ_CONV; // RULE_03
					start_d = 1'b1;
				end
			end
			SEQ_CONV:
			begin
				if (!i_run)
					state_d = SEQ_IDLE; // RULE_04
				else if (cnt_q == '0)
				begin
					ch_d    = o_channel + 3'h1; // RULE_06
					start_d = 1'b1; // RULE_04
				end
				else
					cnt_d = cnt_q - DWELL_W'(1);
			end
			default:
				state_d = SEQ_IDLE;
		endcase
		if (start_d)
			cnt_d = dwell; // RULE_06
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_q   <= SEQ_IDLE;
			cnt_q     <= '0;
			o_channel <= 3'h0;
			o_start   <= 1'b0;
		end
		else if (i_ce)
		begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			o_channel <= ch_d;
			o_start   <= start_d;
		end
	end

endmodule

// ===== hdl/lsa_top.sv
// Behaviour
// RULE_01 - High limit flags only when strictly above
// RULE_02 - Low limit flags when at or below
// RULE_03 - Start bit set begins round-robin conversions
// RULE_04 - Cycle repeats until start bit cleared
// RULE_05 - Each result lands in its value register
// RULE_06 - Eight channels, per-kind dwell times
// RULE_07 - Fan periods checked independently of sequencer
// RULE_08 - Out-of-limit result sets channel status bit
// RULE_09 - Status sticky; read clears only gone conditions
// RULE_10 - Status one bit seven summarises status two
// RULE_11 - Status one bits map analog channels
// RULE_12 - Status two diode faults and fans
// RULE_13 - Status two fan four, overtemp, twelve volt
// RULE_14 - Alert low while unmasked status stays set
// RULE_15 - Masks gate alert only, never status
// RULE_16 - Mask one mirrors status one, bit seven
// RULE_17 - Mask two mirrors status two
// RULE_18 - Alert disabled at reset until enabled
// RULE_19 - Host reads, masks, services, polls, unmasks
// RULE_20 - Fan period above 16-bit limit flags
// RULE_21 - Alert when status and not mask nonzero
`timescale 1ns/1ps
module lsa_top
	import lsa_pkg::*;
#(
	parameter int unsigned P_VOLT_CYC   = VOLT_CYC,
	parameter int unsigned P_LOCAL_CYC  = LOCAL_CYC,
	parameter int unsigned P_REMOTE_CYC = REMOTE_CYC
)
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_reg_rvalid,
	output logic             o_conv_start,
	output logic      [2:0]  o_conv_channel,
	input  wire logic        i_conv_done,
	input  wire logic [7:0]  i_conv_data,
	input  wire logic        i_tach_done,
	input  wire logic [1:0]  i_tach_index,
	input  wire logic [15:0] i_tach_period,
	input  wire logic [1:0]  i_diode_fault,
	input  wire logic        i_overtemp,
	input  wire logic        i_thermal_event_pin_limit_over,
	input  wire logic        i_vid_mode,
	input  wire logic        i_vid_change,
	output logic             o_alert_n,
	output logic             o_alert_oe
);

	logic [7:0]  cfg_one_q, cfg_one_d, cfg_three_q, cfg_three_d;
	logic [7:0]  mask_one_q, mask_one_d, mask_two_q, mask_two_d;
	logic [7:0]  lim_q [16];
	logic [7:0]  lim_d [16];
	logic [7:0]  tlim_q [8];
	logic [7:0]  tlim_d [8];
	logic [15:0] stat_q, stat_d, cond_q, cond_d, ev, clr;
	logic [7:0]  lo_lim, hi_lim, rd_d, rd_q, rdata_d, mem_rdata;
	logic        hi_viol, lo_viol, oor, is_temp, tach_oor;
	logic [15:0] tach_lim;
	logic [3:0]  st_idx;
	logic        alert_any, alert_n_d;
	logic        rd_pend_q, rd_mem_q, mem_hit;
	logic [7:0]  status_one_view;

	// ****************************************************************
	// Sequencer and value storage
	// ****************************************************************
	lsa_sequencer #(
		.P_VOLT_CYC   (P_VOLT_CYC),
		.P_LOCAL_CYC  (P_LOCAL_CYC),
		.P_REMOTE_CYC (P_REMOTE_CYC)
	) u_seq (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_run     (cfg_one_q[CFG1_START_BIT]), // RULE_03
		.o_start   (o_conv_start),
		.o_channel (o_conv_channel)
	);

	lsa_value_mem u_mem (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_we    (i_conv_done), // RULE_05
		.i_waddr (o_conv_channel),
		.i_wdata (i_conv_data),
		.i_raddr (i_reg_addr[2:0]),
		.o_rdata (mem_rdata)
	);

	// ****************************************************************
	// Limit comparison
	// ****************************************************************
	// Temperatures are twos complement, voltages plain binary
	always_comb
	begin
		lo_lim  = lim_q[{o_conv_channel, 1'b0}];
		hi_lim  = lim_q[{o_conv_channel, 1'b1}];
		is_temp = (int'(o_conv_channel) >= NUM_VOLT_CH);
		if (is_temp)
		begin
			hi_viol = $signed(i_conv_data) > $signed(hi_lim); // RULE_01
			lo_viol = $signed(i_conv_data) <= $signed(lo_lim); // RULE_02
		end
		else
		begin
			hi_viol = i_conv_data > hi_lim; // RULE_01
			lo_viol = i_conv_data <= lo_lim; // RULE_02
		end
		oor      = hi_viol || lo_viol;
		st_idx   = CH_STAT_MAP[o_conv_channel*4 +: 4];
		tach_lim = {tlim_q[{i_tach_index, 1'b1}],
			tlim_q[{i_tach_index, 1'b0}]};
		tach_oor = i_tach_period > tach_lim; // RULE_20
	end

	// ****************************************************************
	// Conditions and sticky status
	// ****************************************************************
	// Tach path has its own strobe, free of the analog slots
	always_comb
	begin
		cond_d = cond_q;
		if (i_conv_done)
			cond_d[st_idx] = oor; // RULE_08 RULE_11
		if (i_tach_done)
			cond_d[8 + ST2_FAN_ONE + int'(i_tach_index)] = tach_oor; // RULE_07
		cond_d[8 + ST2_DIODE_TWO] = i_diode_fault[1]; // RULE_12
		cond_d[8 + ST2_DIODE_ONE] = i_diode_fault[0]; // RULE_12
		cond_d[8 + ST2_OVERTEMP]  = i_overtemp; // RULE_13
		if (cfg_three_q[CFG3_THERMAL_EVENT_PIN_EN_BIT])
			cond_d[8 + ST2_FAN_FOUR] = i_thermal_event_pin_limit_over; // RULE_13
		if (i_vid_mode)
			cond_d[8 + ST2_TWELVE_VOLT] = i_vid_change; // RULE_13
		cond_d[ST1_SUMMARY_BIT] = 1'b0;
		ev = '0;
		if (i_conv_done)
			ev[st_idx] = oor && !(i_vid_mode && st_idx == 4'(8));
		if (i_tach_done && !(i_tach_index == 2'h3 &&
			cfg_three_q[CFG3_THERMAL_EVENT_PIN_EN_BIT]))
			ev[8 + ST2_FAN_ONE + int'(i_tach_index)] = tach_oor;
		ev[15:14] = i_diode_fault;
		ev[8 + ST2_OVERTEMP] = i_overtemp;
		if (cfg_three_q[CFG3_THERMAL_EVENT_PIN_EN_BIT])
			ev[8 + ST2_FAN_FOUR] = i_thermal_event_pin_limit_over;
		if (i_vid_mode)
			ev[8 + ST2_TWELVE_VOLT] = i_vid_change;
		clr = '0;
		if (i_reg_rd && i_reg_addr == ADDR_STATUS_ONE)
			clr[7:0] = ~cond_q[7:0]; // RULE_09
		if (i_reg_rd && i_reg_addr == ADDR_STATUS_TWO)
			clr[15:8] = ~cond_q[15:8]; // RULE_09
		// A new event in the clearing cycle wins over the clear
		stat_d = (stat_q & ~clr) | ev; // RULE_08 RULE_09 RULE_15
		stat_d[ST1_SUMMARY_BIT] = 1'b0;
	end

	// Bit seven is computed, never stored
	always_comb
	begin
		status_one_view = stat_q[7:0];
		status_one_view[ST1_SUMMARY_BIT] = |stat_q[15:8]; // RULE_10
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_comb
	begin
		cfg_one_d   = cfg_one_q;
		cfg_three_d = cfg_three_q;
		mask_one_d  = mask_one_q;
		mask_two_d  = mask_two_q;
		for (int i = 0; i < 16; i++)
			lim_d[i] = lim_q[i];
		for (int i = 0; i < 8; i++)
			tlim_d[i] = tlim_q[i];
		if (i_reg_wr)
		begin
			case (i_reg_addr)
				ADDR_CFG_ONE:   cfg_one_d   = i_reg_wdata; // RULE_03 RULE_04
				ADDR_CFG_THREE: cfg_three_d = i_reg_wdata; // RULE_18
				ADDR_MASK_ONE:  mask_one_d  = i_reg_wdata; // RULE_16
				ADDR_MASK_TWO:  mask_two_d  = i_reg_wdata; // RULE_17
				default:
				begin
					if (i_reg_addr >= ADDR_LIMIT_BASE &&
						i_reg_addr < ADDR_TACH_BASE)
						lim_d[4'(i_reg_addr - ADDR_LIMIT_BASE)] = i_reg_wdata;
					else if (i_reg_addr >= ADDR_TACH_BASE &&
						i_reg_addr < ADDR_TACH_BASE + 8'h08)
						tlim_d[3'(i_reg_addr - ADDR_TACH_BASE)] = i_reg_wdata;
				end
			endcase
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	// Two-cycle latency for all addresses, so value reads line up
	always_comb
	begin
		mem_hit = (i_reg_addr[7:3] == ADDR_VALUE_BASE[7:3]);
		rd_d    = REG_RST;
		case (i_reg_addr)
			ADDR_CFG_ONE:    rd_d = cfg_one_q;
			ADDR_STATUS_ONE: rd_d = status_one_view; // RULE_10 RULE_11
			ADDR_STATUS_TWO: rd_d = stat_q[15:8]; // RULE_12 RULE_13
			ADDR_MASK_ONE:   rd_d = mask_one_q;
			ADDR_MASK_TWO:   rd_d = mask_two_q;
			ADDR_CFG_THREE:  rd_d = cfg_three_q;
			default:
			begin
				if (i_reg_addr >= ADDR_LIMIT_BASE &&
					i_reg_addr < ADDR_TACH_BASE)
					rd_d = lim_q[4'(i_reg_addr - ADDR_LIMIT_BASE)];
				else if (i_reg_addr >= ADDR_TACH_BASE &&
					i_reg_addr < ADDR_TACH_BASE + 8'h08)
					rd_d = tlim_q[3'(i_reg_addr - ADDR_TACH_BASE)];
			end
		endcase
		rdata_d = rd_mem_q ? mem_rdata : rd_q;
	end

	// ****************************************************************
	// Alert output
	// ****************************************************************
	// Mask one bit seven silences every status two source
	always_comb
	begin
		alert_any = (|(stat_q[6:0] & ~mask_one_q[6:0])) ||
			((|(stat_q[15:8] & ~mask_two_q)) &&
			!mask_one_q[ST1_SUMMARY_BIT]); // RULE_14 RULE_15 RULE_16 RULE_17 RULE_21
		alert_n_d = !(cfg_three_q[CFG3_ALERT_EN_BIT] && alert_any); // RULE_18
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cfg_one_q    <= REG_RST;
			cfg_three_q  <= REG_RST; // RULE_18
			mask_one_q   <= REG_RST;
			mask_two_q   <= REG_RST;
			for (int i = 0; i < 16; i++)
				lim_q[i] <= (i < 2*NUM_VOLT_CH) ?
					((i % 2 == 1) ? VOLT_HI_RST : VOLT_LO_RST) :
					((i % 2 == 1) ? TEMP_HI_RST : TEMP_LO_RST);
			for (int i = 0; i < 8; i++)
				tlim_q[i] <= TACH_LIM_RST;
			stat_q       <= '0;
			cond_q       <= '0;
			rd_q         <= REG_RST;
			rd_pend_q    <= 1'b0;
			rd_mem_q     <= 1'b0;
			o_reg_rdata  <= REG_RST;
			o_reg_rvalid <= 1'b0;
			o_alert_n    <= 1'b1;
			o_alert_oe   <= 1'b0;
		end
		else if (i_ce)
		begin
			cfg_one_q    <= cfg_one_d;
			cfg_three_q  <= cfg_three_d;
			mask_one_q   <= mask_one_d;
			mask_two_q   <= mask_two_d;
			lim_q        <= lim_d;
			tlim_q       <= tlim_d;
			stat_q       <= stat_d;
			cond_q       <= cond_d;
			rd_q         <= rd_d;
			rd_pend_q    <= i_reg_rd;
			rd_mem_q     <= mem_hit;
			o_reg_rdata  <= rdata_d;
			o_reg_rvalid <= rd_pend_q;
			o_alert_n    <= alert_n_d; // RULE_14
			o_alert_oe   <= !alert_n_d;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_high_strict: assert property (@(posedge i_clk) disable iff (i_rst)
		i_conv_done && !is_temp && i_conv_data == hi_lim &&
		i_conv_data > lo_lim |-> !oor) // RULE_01
		else $error("equal to high limit flagged");
	a_low_equal: assert property (@(posedge i_clk) disable iff (i_rst)
		i_conv_done && i_conv_data == lo_lim |-> oor) // RULE_02
		else $error("equal to low limit not flagged");
	a_start_run: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_reg_wr && i_reg_addr == ADDR_CFG_ONE &&
		i_reg_wdata[0] && !cfg_one_q[0] ##1 i_ce [*2]
		|-> o_conv_start) // RULE_03
		else $error("start bit did not begin conversions");
	a_stop_halts: assert property (@(posedge i_clk) disable iff (i_rst)
		!cfg_one_q[0] && $past(!cfg_one_q[0]) |-> !o_conv_start) // RULE_04
		else $error("conversion started while stopped");
	a_event_sets: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_conv_done && oor && !i_vid_mode
		|=> stat_q[$past(st_idx)]) // RULE_08 RULE_15
		else $error("out of limit result left status clear");
	a_sticky_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && stat_q[4] && !(i_reg_rd && i_reg_addr == ADDR_STATUS_ONE)
		|=> stat_q[4]) // RULE_09
		else $error("sticky status dropped without a read");
	a_read_clears: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_reg_rd && i_reg_addr == ADDR_STATUS_ONE &&
		!cond_q[0] && !ev[0] |=> !stat_q[0]) // RULE_09
		else $error("read did not clear a gone condition");
	a_summary_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_reg_rd && i_reg_addr == ADDR_STATUS_ONE ##1 i_ce [*2]
		|-> o_reg_rdata[7] == $past(|stat_q[15:8], 2)) // RULE_10
		else $error("summary bit wrong");
	a_alert_off: assert property (@(posedge i_clk) disable iff (i_rst)
		!cfg_three_q[0] && $past(!cfg_three_q[0]) |-> o_alert_n) // RULE_18
		else $error("alert driven while disabled");
	a_alert_on: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && cfg_three_q[0] && (|(stat_q[6:0] & ~mask_one_q[6:0]))
		|=> !o_alert_n && o_alert_oe) // RULE_14 RULE_21
		else $error("unmasked status did not raise alert");

	c_alert_seen: cover property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_alert_n));
	c_read_clear: cover property (@(posedge i_clk) disable iff (i_rst)
		$fell(stat_q[0]));
	c_wrap: cover property (@(posedge i_clk) disable iff (i_rst)
		o_conv_start && o_conv_channel == 3'h0 && $past(o_conv_channel) == 3'h7);

endmodule

// ===== test/lsa_adc_model.sv
`timescale 1ns/1ps
module lsa_adc_model
(
	input  wire logic            i_clk,
	input  wire logic            i_rst,
	input  wire logic            i_start,
	input  wire logic [2:0]      i_channel,
	input  wire logic [7:0][7:0] i_values,
	input  wire logic            i_slow,
	output logic                 o_done,
	output logic      [7:0]      o_data
);
	// ****************************************************************
	// Converter stand-in
	// ****************************************************************
	int         cnt_q = 0;
	logic [2:0] ch_q  = 3'h0;

	initial
	begin
		o_done = 1'b0;
		o_data = 8'h5A;
	end

	// Result comes 3 or 12 cycles after start, inside the shortest slot
	always @(posedge i_clk)
	begin
		o_done <= 1'b0;
		o_data <= ~o_data; // Data bus alternates between the last result and its inverse
		if (i_rst)
			cnt_q <= 0;
		else if (i_start)
		begin
			ch_q  <= i_channel;
			cnt_q <= i_slow ? 12 : 3;
		end
		else if (cnt_q > 0)
		begin
			cnt_q <= cnt_q - 1;
			if (cnt_q == 1)
			begin
				o_done <= 1'b1;
				o_data <= i_values[ch_q];
			end
		end
	end
endmodule

// ===== test/lsa_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module lsa_top_bench
	import lsa_pkg::*;
;
	// ****************************************************************
	// Stimulus and observation
	// ****************************************************************
	localparam int VC = 20;
	localparam int LC = 24;
	localparam int RC = 50;
	localparam int STMAP [8] = '{0, 1, 2, 3, 8, 4, 5, 6};
	localparam logic [7:0] BV [5] = '{8'h80, 8'h81, 8'h41, 8'h40, 8'h41};
	localparam logic [4:0] LV [4] = '{5'b11000, 5'b00100, 5'b00010, 5'b00001};
	localparam logic [7:0] LE [4] = '{8'hC0, 8'h02, 8'h01, 8'h20};
	typedef struct {string nm; logic [7:0] e;} lsa_note_t;
	logic clk = 0, rst = 1, rd = 0, wr = 0, tdone = 0, overtemperature_flag = 0, tlim = 0;
	logic vmode = 0, vchg = 0, slow = 0, cdone, rvalid, cstart;
	logic alert_n, alert_oe;
	logic [7:0]      addr = 0, wdata = 0, cdata, rdata;
	logic [1:0]      tidx = 0, dfault = 0;
	logic [15:0]     tper = 0, m;
	logic [2:0]      cch;
	logic [7:0][7:0] vals;
	int              failures = 0, total_checks = 0, seed = 96561, i, c, k;
	lsa_note_t       notes[$];
	lsa_note_t       nt;

	// Clock at 100 MHz
	initial
	begin
		forever #5 clk = ~clk;
	end

	lsa_top #(.P_VOLT_CYC(VC), .P_LOCAL_CYC(LC), .P_REMOTE_CYC(RC)) dut_u
	(
		.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_conv_start(cstart),
		.o_conv_channel(cch), .i_conv_done(cdone), .i_conv_data(cdata),
		.i_tach_done(tdone), .i_tach_index(tidx), .i_tach_period(tper),
		.i_diode_fault(dfault), .i_overtemp(overtemperature_flag),
		.i_thermal_event_pin_limit_over(tlim), .i_vid_mode(vmode),
		.i_vid_change(vchg), .o_alert_n(alert_n), .o_alert_oe(alert_oe)
	);

	lsa_adc_model adc_u
	(
		.i_clk(clk), .i_rst(rst), .i_start(cstart), .i_channel(cch),
		.i_values(vals), .i_slow(slow), .o_done(cdone), .o_data(cdata)
	);

	function automatic int dwell(input int ch);
		return ch < 5 ? VC : (ch == 6 ? LC : RC);
	endfunction

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	// Note the expectation, then let the answer land before moving on
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		notes.push_back('{$sformatf("reg %h", a), e});
		@(negedge clk);
		rd = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// Wait for a fresh conversion of one channel and its result
	task automatic wait_conv(input int ch);
		int n;
		n = 0;
		do @(negedge clk);
		while (!(cstart === 1'b1 && cch === 3'(ch)) && ++n < 2000);
		while (cdone !== 1'b1 && ++n < 2000) @(negedge clk);
		repeat (3) @(negedge clk);
		`CHK("conversion wait", 1'b1, n < 2000)
	endtask

	task automatic tach(input logic [1:0] ix, input logic [15:0] p);
		@(negedge clk);
		tidx = ix;
		tper = p;
		tdone = 1'b1;
		@(negedge clk);
		tdone = 1'b0;
	endtask

	task automatic stop_test;
		$display("Checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Oldest noted read answer is matched with each returned byte
	// Sampled mid-cycle, where the registered answer has settled
	always @(negedge clk)
		if (rvalid === 1'b1)
		begin
			nt = notes.pop_front();
			`CHK(nt.nm, nt.e, rdata)
		end

	// Hang guard, far beyond the expected run length
	initial
	begin
		#800_000;
		failures++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		for (i = 0; i < 8; i++)
			vals[i] = 8'h01 | (8'($random(seed)) & 8'h7F);
		repeat (3) @(negedge clk);
		rst = 1'b0;
		`CHK("alert after reset", 1'b1, alert_n)
		rd_reg(ADDR_STATUS_ONE, 8'h00);
		rd_reg(ADDR_STATUS_TWO, 8'h00);
		rd_reg(8'h00, 8'h00);
		wr_reg(ADDR_MASK_ONE, 8'hA5);
		wr_reg(ADDR_MASK_TWO, 8'h5A);
		rd_reg(ADDR_MASK_ONE, 8'hA5);
		rd_reg(ADDR_MASK_TWO, 8'h5A);
		wr_reg(ADDR_MASK_ONE, 8'h00);
		wr_reg(ADDR_MASK_TWO, 8'h00);
		// Start spacing and channel order over one wrap
		wr_reg(ADDR_CFG_ONE, 8'h01);
		k = 0;
		for (c = 0; c < 9; c++)
		begin
			while (cstart !== 1'b1 && k < 200)
			begin
				@(negedge clk);
				k++;
			end
			`CHK("start gap", c == 0 ? 1 : dwell(c - 1), k)
			`CHK("channel", 3'(c % 8), cch)
			@(negedge clk);
			k = 1;
		end
		// Every result reaches its value register, prompt and slow
		for (c = 0; c < 8; c++)
		begin
			slow = c[0];
			wait_conv(c);
			rd_reg(ADDR_VALUE_BASE + 8'(c), vals[c]);
		end
		// Limit boundaries on one voltage channel
		wr_reg(ADDR_LIMIT_BASE, 8'h40);
		wr_reg(ADDR_LIMIT_BASE + 8'h01, 8'h80);
		for (i = 0; i < 5; i++)
		begin
			vals[0] = BV[i];
			wait_conv(0);
			rd_reg(ADDR_STATUS_ONE, 8'((5'b11110 >> i) & 5'h01));
			rd_reg(ADDR_STATUS_ONE, 8'((5'b01010 >> i) & 5'h01));
		end
		// Bit position of each channel, one at a time
		for (c = 0; c < 8; c++)
		begin
			m = 16'h1 << STMAP[c];
			wr_reg(ADDR_LIMIT_BASE + 8'(2 * c + 1), 8'h00);
			wait_conv(c);
			rd_reg(ADDR_STATUS_ONE, {|m[15:8], m[6:0]});
			rd_reg(ADDR_STATUS_TWO, m[15:8]);
			wr_reg(ADDR_LIMIT_BASE + 8'(2 * c + 1), c < 5 ? 8'hFF : 8'h7F);
			wait_conv(c);
			rd_reg(ADDR_STATUS_ONE, {|m[15:8], m[6:0]});
			rd_reg(ADDR_STATUS_TWO, m[15:8]);
			rd_reg(ADDR_STATUS_ONE, 8'h00);
			rd_reg(ADDR_STATUS_TWO, 8'h00);
		end
		// Fan periods against a 16-bit limit while conversions run
		for (c = 0; c < 4; c++)
		begin
			wr_reg(ADDR_TACH_BASE + 8'(2 * c), 8'h00);
			wr_reg(ADDR_TACH_BASE + 8'(2 * c + 1), 8'h10);
			tach(2'(c), 16'h1000);
			rd_reg(ADDR_STATUS_TWO, 8'h00);
			tach(2'(c), 16'h1001);
			rd_reg(ADDR_STATUS_TWO, 8'h04 << c);
			tach(2'(c), 16'h0FFF);
			rd_reg(ADDR_STATUS_TWO, 8'h04 << c);
			rd_reg(ADDR_STATUS_TWO, 8'h00);
		end
		// Level sources, with VID and thermal reporting selected
		vmode = 1'b1;
		wr_reg(ADDR_CFG_THREE, 8'h02);
		for (i = 0; i < 4; i++)
		begin
			{dfault, overtemperature_flag, vchg, tlim} = LV[i];
			rd_reg(ADDR_STATUS_TWO, LE[i]);
			{dfault, overtemperature_flag, vchg, tlim} = 5'b0;
			rd_reg(ADDR_STATUS_TWO, LE[i]);
			rd_reg(ADDR_STATUS_TWO, 8'h00);
		end
		// Alert output: enable, masks and the host's handling order
		overtemperature_flag = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("alert disabled", 1'b1, alert_n)
		wr_reg(ADDR_CFG_THREE, 8'h03);
		repeat (3) @(negedge clk);
		`CHK("alert", 1'b0, alert_n)
		`CHK("alert enable", 1'b1, alert_oe)
		rd_reg(ADDR_STATUS_TWO, 8'h02);
		wr_reg(ADDR_MASK_TWO, 8'h02);
		repeat (3) @(negedge clk);
		`CHK("alert masked", 1'b1, alert_n)
		rd_reg(ADDR_STATUS_TWO, 8'h02);
		wr_reg(ADDR_MASK_TWO, 8'h00);
		wr_reg(ADDR_MASK_ONE, 8'h80);
		repeat (3) @(negedge clk);
		`CHK("alert summary mask", 1'b1, alert_n)
		wr_reg(ADDR_MASK_ONE, 8'h00);
		overtemperature_flag = 1'b0;
		repeat (3) @(negedge clk);
		`CHK("alert held", 1'b0, alert_n)
		rd_reg(ADDR_STATUS_TWO, 8'h02);
		`CHK("alert released", 1'b1, alert_n)
		// Clearing the start bit stops the round robin
		wr_reg(ADDR_CFG_ONE, 8'h00);
		k = 0;
		repeat (300)
		begin
			@(negedge clk);
			k += int'(cstart === 1'b1);
		end
		`CHK("starts after stop", 0, k)
		`CHK("channel after stop", 3'h0, cch)
		stop_test();
	end
endmodule
